// >>> src/pwmido_pkg.sv
// Package with constants for the PWM interrupt, output and duty block
package pwmido_pkg;
    localparam int CNT_W      = 15;
    localparam int DUTY_W     = 16;
    localparam int NUM_GEN    = 4;
    localparam int NUM_PAIR   = 4;
    localparam int MODE_W     = 2;
    localparam int POST_W     = 4;
    // Field positions inside the control words
    localparam int TB_MODE_LSB    = 0;
    localparam int TB_MODE_MSB    = 1;
    localparam int TB_POST_LSB    = 4;
    localparam int TB_POST_MSB    = 7;
    localparam int TB_ENABLE_BIT  = 15;
    localparam int CTR1_PAIR_MODE_SEL_LSB  = 8;
    localparam int CTR1_PAIR_MODE_SEL_MSB  = 11;
    localparam int CTR2_IUE_BIT   = 2;
    localparam int TMR_DIR_BIT    = 15;
    // Time base mode codes
    localparam logic [1:0] MODE_FREE   = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_UPDN   = 2'h2;
    localparam logic [1:0] MODE_UPDN2  = 2'h3;
    // Reset values
    localparam logic [CNT_W-1:0]  CNT_RST  = 15'h0000;
    localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0000;
    localparam logic [POST_W-1:0] POST_RST = 4'h0;
    localparam logic [3:0]        PAIR_MODE_SEL_RST = 4'h0;
endpackage

// >>> src/pwmido_postscaler.sv
// Postscaler that thins time base interrupt events
`timescale 1ns/1ns
module pwmido_postscaler (
    input  wire logic                      clock_i,
    input  wire logic                      reset_i,
    input  wire logic                      clear_i,
    input  wire logic                      bypass_i,
    input  wire logic [pwmido_pkg::POST_W-1:0] ratio_i,
    input  wire logic                      event_i,
    output logic                           fire_o
);
    logic [pwmido_pkg::POST_W-1:0] count_r;
    logic [pwmido_pkg::POST_W-1:0] count_nxt;
    logic                          fire_nxt;

    always_comb begin
        count_nxt = count_r;
        fire_nxt  = 1'b0;
        if (clear_i) begin
            count_nxt = pwmido_pkg::POST_RST;
        end else if (event_i) begin
            if (bypass_i || count_r == ratio_i) begin
                count_nxt = pwmido_pkg::POST_RST;
                fire_nxt  = 1'b1;
            end else begin
                count_nxt = count_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            count_r <= pwmido_pkg::POST_RST;
            fire_o  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            fire_o  <= fire_nxt;
        end
    end
endmodule

// >>> src/pwmido_top.sv
// Time base, interrupt, output mode and duty buffering logic of the PWM block
`timescale 1ns/1ns
// What this block does
// - Interrupt timing depends on mode field bits 1:0 and postscale field bits 7:4.
// - Free-running mode raises an event when counter resets after period match.
// - Single event mode interrupts on period reset, clears enable, ignores postscaler.
// - Up/down mode raises an event at zero as counting turns upward.
// - Double-update mode interrupts at zero and at period match, no postscaling.
// - Every event passed by the postscaler sets the interrupt flag.
// - Single event drives active on enable, inactive on duty, stops at period.
// - Single event mode produces only edge-aligned waveforms.
// - Edge-aligned: active at counter zero, inactive on duty match.
// - Zero duty holds inactive; duty above period holds active all period.
// - Immediate update loads a written duty straight into the active compare.
// - Up/down: duty match counting down goes active, counting up goes inactive.
// - Complementary pair never drives both outputs active together.
// - Pair mode bits 11:8 pick complementary when clear, independent when set.
// - Independent pair has no dead time and no pin combination limits.
// - Each generator has a writable buffer and a hidden active compare.
// - Modes 0x transfer buffers at period match and counter reset.
// - With time base disabled, duty writes take effect immediately.
// - Mode 10 transfers buffers at zero when counting starts upward.
// - Mode 11 transfers buffers at zero and at period match.
// - Immediate update bit sits at bit 2 of control register 2.
// - Free-running counts up to period, resets next edge, repeats while enabled.
// - Up/down counts to period, reverses, down to zero; direction bit 15.
// - Postscaler ratios span one-to-one through one-to-sixteen before flag.
module pwmido_top (
    input  wire logic                          clock_i,
    input  wire logic                          reset_i,
    input  wire logic                          tick_i,
    input  wire logic [15:0]                   time_base_control_i,
    input  wire logic                          time_base_control_wr_i,
    input  wire logic [15:0]                   control_register_1_i,
    input  wire logic [15:0]                   control_register_2_i,
    input  wire logic [pwmido_pkg::CNT_W-1:0]  period_value_i,
    input  wire logic [pwmido_pkg::DUTY_W-1:0] duty_wdata_i,
    input  wire logic [pwmido_pkg::NUM_GEN-1:0] duty_wr_i,
    input  wire logic                          irq_flag_clear_i,
    output logic                               time_base_enable_o,
    output logic [15:0]                        time_base_counter_o,
    output logic                               pwm_irq_flag_o,
    output logic [pwmido_pkg::NUM_PAIR-1:0]    pwm_high_o,
    output logic [pwmido_pkg::NUM_PAIR-1:0]    pwm_low_o
);
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    logic [1:0] mode;
    logic [3:0] post_sel;
    logic [3:0] pair_indep;
    logic       immediate_update_en;
    logic       up_down;

    assign mode       = time_base_control_i[pwmido_pkg::TB_MODE_MSB:pwmido_pkg::TB_MODE_LSB];
    assign post_sel   = time_base_control_i[pwmido_pkg::TB_POST_MSB:pwmido_pkg::TB_POST_LSB];
    assign pair_indep = control_register_1_i[pwmido_pkg::CTR1_PAIR_MODE_SEL_MSB:pwmido_pkg::CTR1_PAIR_MODE_SEL_LSB];
    assign immediate_update_en        = control_register_2_i[pwmido_pkg::CTR2_IUE_BIT];
    assign up_down    = mode[1];

    // ------------------------------------------------------------
    // Time base counter
    // ------------------------------------------------------------
    logic                         enable_r;
    logic                         enable_nxt;
    logic [pwmido_pkg::CNT_W-1:0] count_r;
    logic [pwmido_pkg::CNT_W-1:0] count_nxt;
    logic                         dir_r;
    logic                         dir_nxt;
    logic                         period_hit;
    logic                         zero_hit;
    logic                         wrap_evt;
    logic                         zero_up_evt;
    logic                         per_evt;
    logic                         raw_evt;
    logic                         bypass_post;
    logic                         post_fire;
    logic                         start_pulse;

    assign period_hit  = enable_r && tick_i && count_r == period_value_i;
    assign zero_hit    = enable_r && tick_i && count_r == pwmido_pkg::CNT_RST;
    assign wrap_evt    = period_hit && !up_down;
    assign zero_up_evt = zero_hit && up_down && dir_r;
    assign per_evt     = period_hit && up_down && !dir_r;
    assign start_pulse = time_base_control_wr_i && time_base_control_i[pwmido_pkg::TB_ENABLE_BIT] && !enable_r;

    always_comb begin
        enable_nxt = enable_r;
        count_nxt  = count_r;
        dir_nxt    = dir_r;
        if (time_base_control_wr_i) begin
            enable_nxt = time_base_control_i[pwmido_pkg::TB_ENABLE_BIT];
        end
        if (enable_r && tick_i) begin
            if (!up_down) begin
                dir_nxt = 1'b0;
                if (period_hit) begin
                    count_nxt = pwmido_pkg::CNT_RST;
                    if (mode == pwmido_pkg::MODE_SINGLE) begin
                        enable_nxt = 1'b0;
                    end
                end else begin
                    count_nxt = count_r + 15'h0001;
                end
            end else begin
                if (!dir_r && period_hit) begin
                    dir_nxt   = 1'b1;
                    count_nxt = count_r - 15'h0001;
                end else if (dir_r && zero_hit) begin
                    dir_nxt   = 1'b0;
                    count_nxt = count_r + 15'h0001;
                end else if (dir_r) begin
                    count_nxt = count_r - 15'h0001;
                end else begin
                    count_nxt = count_r + 15'h0001;
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            enable_r <= 1'b0;
            count_r  <= pwmido_pkg::CNT_RST;
            dir_r    <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            count_r  <= count_nxt;
            dir_r    <= dir_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt events and postscaler
    // ------------------------------------------------------------
    always_comb begin
        raw_evt     = 1'b0;
        bypass_post = 1'b0;
        case (mode)
            pwmido_pkg::MODE_FREE: begin
                raw_evt = wrap_evt;
            end
            pwmido_pkg::MODE_SINGLE: begin
                raw_evt     = wrap_evt;
                bypass_post = 1'b1;
            end
            pwmido_pkg::MODE_UPDN: begin
                raw_evt = zero_up_evt;
            end
            default: begin
                raw_evt     = zero_up_evt || per_evt;
                bypass_post = 1'b1;
            end
        endcase
    end

    pwmido_postscaler u_post (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .clear_i  (time_base_control_wr_i),
        .bypass_i (bypass_post),
        .ratio_i  (post_sel),
        .event_i  (raw_evt),
        .fire_o   (post_fire)
    );

    logic irq_r;
    logic irq_nxt;

    always_comb begin
        irq_nxt = irq_r;
        if (irq_flag_clear_i) begin
            irq_nxt = 1'b0;
        end
        if (post_fire) begin
            irq_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Duty buffering and compare outputs
    // ------------------------------------------------------------
    logic                         update_pt;
    logic [pwmido_pkg::NUM_GEN-1:0] cmp_state;

    always_comb begin
        case (mode)
            pwmido_pkg::MODE_FREE,
            pwmido_pkg::MODE_SINGLE: update_pt = wrap_evt;
            pwmido_pkg::MODE_UPDN:   update_pt = zero_up_evt;
            default:                 update_pt = zero_up_evt || per_evt;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < pwmido_pkg::NUM_GEN; g++) begin : gen_duty
            logic [pwmido_pkg::DUTY_W-1:0] buf_r;
            logic [pwmido_pkg::DUTY_W-1:0] buf_nxt;
            logic [pwmido_pkg::DUTY_W-1:0] act_r;
            logic [pwmido_pkg::DUTY_W-1:0] act_nxt;
            logic                          out_r;
            logic                          out_nxt;
            logic                          over_per;

            assign over_per = act_nxt > {1'b0, period_value_i};

            always_comb begin
                buf_nxt = buf_r;
                act_nxt = act_r;
                if (duty_wr_i[g]) begin
                    buf_nxt = duty_wdata_i;
                end
                if (duty_wr_i[g] && (immediate_update_en || !enable_r)) begin
                    act_nxt = duty_wdata_i;
                end else if (update_pt) begin
                    act_nxt = buf_r;
                end
            end

            always_comb begin
                out_nxt = out_r;
                if (!enable_nxt) begin
                    out_nxt = 1'b0;
                end else if (act_nxt == pwmido_pkg::DUTY_RST) begin
                    out_nxt = 1'b0;
                end else if (over_per) begin
                    out_nxt = 1'b1;
                end else if (!up_down) begin
                    // Edge aligned, also used for single event
                    if (start_pulse || (tick_i && count_nxt == pwmido_pkg::CNT_RST)) begin
                        out_nxt = 1'b1;
                    end
                    if ({1'b0, count_nxt} >= act_nxt) begin
                        out_nxt = 1'b0;
                    end
                    if (duty_wr_i[g] && immediate_update_en && {1'b0, count_nxt} < act_nxt) begin
                        out_nxt = 1'b1;
                    end
                end else begin
                    if (tick_i && dir_nxt && {1'b0, count_nxt} == act_nxt) begin
                        out_nxt = 1'b1;
                    end else if (tick_i && !dir_nxt && {1'b0, count_nxt} == act_nxt) begin
                        out_nxt = 1'b0;
                    end
                    if (duty_wr_i[g] && immediate_update_en) begin
                        out_nxt = {1'b0, count_nxt} < act_nxt;
                    end
                end
            end

            always_ff @(posedge clock_i) begin
                if (reset_i) begin
                    buf_r <= pwmido_pkg::DUTY_RST;
                    act_r <= pwmido_pkg::DUTY_RST;
                    out_r <= 1'b0;
                end else begin
                    buf_r <= buf_nxt;
                    act_r <= act_nxt;
                    out_r <= out_nxt;
                end
            end

            assign cmp_state[g] = out_r;
        end
    endgenerate

    // ------------------------------------------------------------
    // Output pair steering
    // ------------------------------------------------------------
    logic [pwmido_pkg::NUM_PAIR-1:0] high_nxt;
    logic [pwmido_pkg::NUM_PAIR-1:0] low_nxt;
    logic [pwmido_pkg::NUM_PAIR-1:0] high_r;
    logic [pwmido_pkg::NUM_PAIR-1:0] low_r;

    genvar p;
    generate
        for (p = 0; p < pwmido_pkg::NUM_PAIR; p++) begin : gen_pair
            always_comb begin
                if (pair_indep[p]) begin
                    high_nxt[p] = cmp_state[p];
                    low_nxt[p]  = cmp_state[p];
                end else begin
                    high_nxt[p] = cmp_state[p];
                    low_nxt[p]  = !cmp_state[p] && !high_r[p];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            high_r <= pwmido_pkg::PAIR_MODE_SEL_RST;
            low_r  <= pwmido_pkg::PAIR_MODE_SEL_RST;
        end else begin
            high_r <= high_nxt & ~(low_r & ~pair_indep);
            low_r  <= low_nxt;
        end
    end

    assign time_base_enable_o  = enable_r;
    assign time_base_counter_o = {dir_r, count_r};
    assign pwm_irq_flag_o      = irq_r;
    assign pwm_high_o          = high_r;
    assign pwm_low_o           = low_r;
endmodule

// >>> test/pwmido_gate_model.sv
// Gate driver model of the inverter legs on the pair outputs
`timescale 1ns/1ns
module pwmido_gate_model (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic [3:0]  high_i,
    input  wire logic [3:0]  low_i,
    input  wire logic [3:0]  indep_i,
    output logic      [3:0]  node_o,
    output logic      [15:0] shoot_o
);
    always @(posedge clock_i) begin
        if (reset_i) begin
            node_o  <= 4'h0;
            shoot_o <= 16'h0000;
        end else begin
            for (int g = 0; g < 4; g++) begin
                // Shoot-through on a complementary leg only
                if (high_i[g] && low_i[g] && !indep_i[g]) begin
                    shoot_o <= shoot_o + 16'h0001;
                end
                // Floating leg node drifts
                node_o[g] <= high_i[g] ? 1'b1 : (low_i[g] ? 1'b0 : !node_o[g]);
            end
        end
    end
endmodule

// >>> test/pwmido_top_checker.sv
// Assertion checker on the ports of the PWM block
`timescale 1ns/1ns
module pwmido_top_checker (
    input wire logic                            clock_i,
    input wire logic                            reset_i,
    input wire logic                            tick_i,
    input wire logic [15:0]                     time_base_control_i,
    input wire logic                            time_base_control_wr_i,
    input wire logic [15:0]                     control_register_1_i,
    input wire logic [pwmido_pkg::CNT_W-1:0]    period_value_i,
    input wire logic                            irq_flag_clear_i,
    input wire logic                            time_base_enable_o,
    input wire logic [15:0]                     time_base_counter_o,
    input wire logic                            pwm_irq_flag_o,
    input wire logic [pwmido_pkg::NUM_PAIR-1:0] pwm_high_o,
    input wire logic [pwmido_pkg::NUM_PAIR-1:0] pwm_low_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic [1:0]  md;
    logic        st;
    logic        ap;
    logic [14:0] cv;
    assign md = time_base_control_i[1:0];
    assign cv = time_base_counter_o[14:0];
    assign st = time_base_enable_o && tick_i && !time_base_control_wr_i;
    assign ap = cv == period_value_i;
    chk_free_step: assert property (st && md == 2'h0 && !ap |=> cv == $past(cv) + 15'h0001)
        else $error("free count did not step");
    chk_free_wrap: assert property (st && md == 2'h0 && ap |=> cv == 15'h0000)
        else $error("free count did not wrap");
    chk_single_stop: assert property (st && md == 2'h1 && ap |=> !time_base_enable_o && cv == 15'h0000)
        else $error("single event did not stop");
    chk_single_irq: assert property (st && md == 2'h1 && ap |-> ##[1:4] pwm_irq_flag_o)
        else $error("single event flag missing");
    chk_updn_turn: assert property (st && md[1] && ap |=> time_base_counter_o[15])
        else $error("no turn down at period");
    chk_updn_rise: assert property (st && md[1] && time_base_counter_o[15] && cv == 15'h0000 |=> !time_base_counter_o[15])
        else $error("no turn up at zero");
    chk_idle_hold: assert property (!time_base_enable_o && !time_base_control_wr_i |=> $stable(cv) && !time_base_enable_o)
        else $error("idle counter moved");
    chk_enable_write: assert property (time_base_control_wr_i |=> time_base_enable_o == $past(time_base_control_i[15]))
        else $error("enable not written");
    chk_flag_sticky: assert property (pwm_irq_flag_o && !irq_flag_clear_i |=> pwm_irq_flag_o)
        else $error("flag dropped");
    chk_comp_excl: assert property ((pwm_high_o & pwm_low_o & ~control_register_1_i[11:8]) == 4'h0)
        else $error("pair both active");
    chk_dbl_irq: assert property (st && md == 2'h3 && ap |-> ##[1:4] pwm_irq_flag_o)
        else $error("period flag missing");
endmodule
bind pwmido_top pwmido_top_checker chk (.clock_i(clock_i), .reset_i(reset_i), .tick_i(tick_i),
    .time_base_control_i(time_base_control_i), .time_base_control_wr_i(time_base_control_wr_i),
    .control_register_1_i(control_register_1_i), .period_value_i(period_value_i),
    .irq_flag_clear_i(irq_flag_clear_i), .time_base_enable_o(time_base_enable_o),
    .time_base_counter_o(time_base_counter_o), .pwm_irq_flag_o(pwm_irq_flag_o),
    .pwm_high_o(pwm_high_o), .pwm_low_o(pwm_low_o));

// >>> test/pwmido_top_tb.sv
// Self-checking testbench of the PWM block
`timescale 1ns/1ns
module pwmido_top_tb;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        tick_i = 1'b1;
    logic [15:0] ctl = 16'h0000;
    logic        ctl_wr = 1'b0;
    logic [15:0] cr1 = 16'h0900;
    logic [15:0] cr2 = 16'h0000;
    logic [14:0] per = 15'h0009;
    logic [15:0] dwd = 16'h0000;
    logic [3:0]  dwr = 4'h0;
    logic        irq_flag_clear_i = 1'b0;
    logic        ena;
    logic [15:0] cnt;
    logic        flag;
    logic [3:0]  hi;
    logic [3:0]  lo;
    logic [3:0]  node;
    logic [15:0] shoot;
    logic [15:0] hc [4];
    logic        dseen;
    int          n_errors = 0;
    int          compares = 0;
    int          n;
    always #5 clock_i = ~clock_i;
    pwmido_top dut (.clock_i(clock_i), .reset_i(reset_i), .tick_i(tick_i), .time_base_control_i(ctl),
        .time_base_control_wr_i(ctl_wr), .control_register_1_i(cr1), .control_register_2_i(cr2),
        .period_value_i(per), .duty_wdata_i(dwd), .duty_wr_i(dwr), .irq_flag_clear_i(irq_flag_clear_i),
        .time_base_enable_o(ena), .time_base_counter_o(cnt), .pwm_irq_flag_o(flag), .pwm_high_o(hi),
        .pwm_low_o(lo));
    pwmido_gate_model gm (.clock_i(clock_i), .reset_i(reset_i), .high_i(hi), .low_i(lo),
        .indep_i(cr1[11:8]), .node_o(node), .shoot_o(shoot));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout();
        n_errors++;
        print_verdict();
    endtask
    task automatic set_ctl(input logic [15:0] v);
        @(posedge clock_i);
        ctl <= v;
        ctl_wr <= 1'b1;
        @(posedge clock_i);
        ctl_wr <= 1'b0;
    endtask
    task automatic wr_duty(input int g, input logic [15:0] v);
        @(posedge clock_i);
        dwd <= v;
        dwr <= 4'h1 << g;
        @(posedge clock_i);
        dwr <= 4'h0;
    endtask
    task automatic wait_cnt(input logic [14:0] v);
        int k;
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (cnt[14:0] !== v && k < 100);
        if (k >= 100) timeout();
    endtask
    task automatic flag_gap(output int m);
        irq_flag_clear_i <= 1'b1;
        @(posedge clock_i);
        irq_flag_clear_i <= 1'b0;
        m = 1;
        do begin
            @(posedge clock_i);
            m++;
        end while (flag !== 1'b1 && m < 300);
        if (m >= 300) timeout();
    endtask
    task automatic measure(input int cyc);
        for (int g = 0; g < 4; g++) hc[g] = 16'h0000;
        dseen = 1'b0;
        repeat (cyc) begin
            @(posedge clock_i);
            for (int g = 0; g < 4; g++) hc[g] += 16'(hi[g]);
            dseen |= cnt[15];
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_single();
        wr_duty(0, 16'h0003);
        set_ctl(16'h8051);
        measure(16);
        check(hc[0], 16'h0003);
        check({15'h0000, ena}, 16'h0000);
        check({15'h0000, flag}, 16'h0001);
        check(cnt, 16'h0000);
        check({12'h000, hi}, 16'h0000);
    endtask
    task automatic sc_free();
        wr_duty(0, 16'h0004);
        wr_duty(2, 16'h0014);
        wr_duty(3, 16'h0005);
        set_ctl(16'h8000);
        flag_gap(n);
        flag_gap(n);
        check(16'(n), 16'h000a);
        measure(10);
        check(hc[0], 16'h0004);
        check(hc[1], 16'h0000);
        check(hc[2], 16'h000a);
        check(hc[3], 16'h0005);
        check({8'h00, hi, lo}, 16'h00db);
        check({14'h0000, node[2:1]}, 16'h0002);
        set_ctl(16'h8020);
        flag_gap(n);
        flag_gap(n);
        check(16'(n), 16'h001e);
    endtask
    task automatic sc_buffer();
        wait_cnt(15'h0001);
        wr_duty(0, 16'h0006);
        repeat (3) @(posedge clock_i);
        check({15'h0000, hi[0]}, 16'h0000);
        wait_cnt(15'h0000);
        repeat (3) @(posedge clock_i);
        measure(10);
        check(hc[0], 16'h0006);
        cr2 <= 16'h0004;
        wait_cnt(15'h0001);
        wr_duty(1, 16'h0008);
        repeat (3) @(posedge clock_i);
        check({15'h0000, hi[1]}, 16'h0001);
        cr2 <= 16'h0000;
    endtask
    task automatic sc_updown();
        set_ctl(16'h8002);
        flag_gap(n);
        flag_gap(n);
        check(16'(n), 16'h0012);
        measure(18);
        check(hc[0], 16'h000c);
        check(hc[2], 16'h0012);
        check({15'h0000, dseen}, 16'h0001);
        set_ctl(16'h8033);
        flag_gap(n);
        flag_gap(n);
        check(16'(n), 16'h0009);
        check(shoot, 16'h0000);
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        @(posedge clock_i);
        check(cnt, 16'h0000);
        check({11'h000, flag, hi}, 16'h0000);
        check({12'h000, lo & hi}, 16'h0000);
        sc_single();
        sc_free();
        sc_buffer();
        sc_updown();
        print_verdict();
    end
endmodule
